//--- src/pll_sel_consts.vh
// Purpose: Shared offsets, fields, reset values and timing for input select and fault monitor
// Assumes: 100 MHz register clock, 32-bit register data
// Notes:   Per-channel groups are indexed by address bits 3:2
`ifndef PLL_SEL_CONSTS_VH
`define PLL_SEL_CONSTS_VH

`define CLK_PERIOD_NS     10
`define LOCK_TIME_NS      2000
`define LOCK_CYC          (`LOCK_TIME_NS / `CLK_PERIOD_NS)
`define PREC_WIN_TICKS    500000
`define FAST_WIN_TICKS    1000
`define FAST_THR_COUNTS   4

`define REG_CTRL          8'h00
`define REG_MON_CFG       8'h04
`define REG_LOS_SENS      8'h08
`define REG_OOF_CFG       8'h0c
`define REG_STATUS        8'h10
`define REG_STICKY        8'h14
`define GRP_CH_CFG        4'h2
`define GRP_CH_STEP       4'h3
`define GRP_CH_STAT       4'h4
`define GRP_CH_OFFSET     4'h5

`define CTRL_EXT_REF      0
`define CTRL_KEEP_OUT     1
`define CTRL_PREDIV_LSB   8
`define CTRL_OOFREF_LSB   16
`define MON_REF_LOS_DIS   4
`define MON_PREC_DIS      8
`define MON_FAST_DIS      9
`define OOF_HYS_LSB       8
`define REFLOS_SENS_LSB   16
`define ST_REF_LOS        4
`define ST_OOF_LSB        8
`define ST_LOL_LSB        16
`define CH_AUTO           0
`define CH_MSEL_LSB       1
`define CH_REVERT         3
`define CH_HITLESS        4
`define CH_PRIO_LSB       8
`define CH_CMD_UP         30
`define CH_CMD_DOWN       31

`define CTRL_RESET        32'h0000_0000
`define MON_CFG_RESET     32'h0000_0000
`define LOS_SENS_RESET    32'h1010_1010
`define OOF_CFG_RESET     32'h0010_0302
`define CH_CFG_RESET      32'h0000_e401

`define MODE_FREERUN      4'b0001
`define MODE_ACQUIRE      4'b0010
`define MODE_LOCKED       4'b0100
`define MODE_HOLDOVER     4'b1000

`endif

//--- src/clock_monitor.v
// Purpose: Loss-of-signal and out-of-frequency monitor for one clock pin
// Assumes: Monitored clock well below half the register clock rate
// Notes:   Frequency is compared as edges per window of zero-ppm reference ticks
`timescale 1ns/100ps
`include "pll_sel_consts.vh"
module clock_monitor #(
  parameter PREC_WIN = `PREC_WIN_TICKS,
  parameter FAST_WIN = `FAST_WIN_TICKS,
  parameter CW       = 22
) (
  input  wire       clock_i,
  input  wire       rst_n_i,
  input  wire       clk_pin_i,
  input  wire       ref_tick_i,
  input  wire       los_dis_i,
  input  wire [7:0] los_sens_i,
  input  wire       prec_dis_i,
  input  wire       fast_dis_i,
  input  wire       oof_dis_i,
  input  wire [7:0] oof_thr_i,
  input  wire [7:0] oof_hys_i,
  output wire       edge_o,
  output reg        los_o,
  output wire       oof_o
);
  localparam [CW-1:0] PW = PREC_WIN[CW-1:0];
  localparam [CW-1:0] FW = FAST_WIN[CW-1:0];
  localparam [CW-1:0] FT = {{(CW-8){1'b0}}, 8'd `FAST_THR_COUNTS};

  reg          s1, s2, s3;
  reg [11:0]   gap;
  reg [CW-1:0] pw, pe, fw, fe, fprev;
  reg          poof, foof, fvalid;

  // s1 feeds only s2
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= clk_pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end
  assign edge_o = s2 & ~s3;

  wire [CW-1:0] pe_n = pe + {{(CW-1){1'b0}}, edge_o};
  wire [CW-1:0] fe_n = fe + {{(CW-1){1'b0}}, edge_o};
  wire [CW-1:0] pdev = (pe_n > PW) ? pe_n - PW : PW - pe_n;
  wire [CW-1:0] fdev = (fe_n > fprev) ? fe_n - fprev : fprev - fe_n;
  wire [CW-1:0] thr  = {{(CW-8){1'b0}}, oof_thr_i};
  wire [CW-1:0] hys  = {{(CW-8){1'b0}}, oof_hys_i};

  // Period watch: sensitivity is the gap allowed in 16-cycle units
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      gap   <= 12'h000;
      los_o <= 1'b0;
    end else begin
      if (edge_o)
        gap <= 12'h000;
      else if (gap != 12'hfff)
        gap <= gap + 12'h001;
      los_o <= !los_dis_i && !edge_o && (gap >= {los_sens_i, 4'h0});
    end
  end

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      pw     <= {CW{1'b0}};
      pe     <= {CW{1'b0}};
      poof   <= 1'b0;
      fw     <= {CW{1'b0}};
      fe     <= {CW{1'b0}};
      fprev  <= {CW{1'b0}};
      foof   <= 1'b0;
      fvalid <= 1'b0;
    end else begin
      if (ref_tick_i && pw == PW - 1'b1) begin
        pw <= {CW{1'b0}};
        pe <= {CW{1'b0}};
        if (pdev > thr)
          poof <= 1'b1;
        else if (pdev + hys <= thr)
          poof <= 1'b0;
      end else begin
        pw <= pw + {{(CW-1){1'b0}}, ref_tick_i};
        pe <= pe_n;
      end
      if (ref_tick_i && fw == FW - 1'b1) begin
        fw     <= {CW{1'b0}};
        fe     <= {CW{1'b0}};
        fprev  <= fe_n;
        fvalid <= 1'b1;
        foof   <= fvalid && (fdev > FT);
      end else begin
        fw <= fw + {{(CW-1){1'b0}}, ref_tick_i};
        fe <= fe_n;
      end
    end
  end

  assign oof_o = !oof_dis_i && ((poof && !prec_dis_i) || (foof && !fast_dis_i));
endmodule

//--- src/pll_input_select_fault_monitor.v
// Purpose: Per-channel input selection, step mode and input fault monitoring
// Assumes: Input and reference pins are asynchronous and slow versus clock_i
// Notes:   Channel loop dynamics are reduced to a fixed lock time
`timescale 1ns/100ps
`include "pll_sel_consts.vh"
module pll_input_select_fault_monitor #(
  parameter NCH      = 4,
  parameter FSW_W    = 24,
  parameter FO_W     = 32,
  parameter PREC_WIN = `PREC_WIN_TICKS,
  parameter FAST_WIN = `FAST_WIN_TICKS
) (
  input  wire                clock_i,
  input  wire                rst_n_i,
  input  wire [3:0]          clock_input_i,
  input  wire                ref_pin_i,
  input  wire [NCH-1:0]      freq_step_up_i,
  input  wire [NCH-1:0]      freq_step_down_i,
  input  wire [7:0]          reg_addr_i,
  input  wire [31:0]         reg_wdata_i,
  input  wire                reg_wr_i,
  input  wire                reg_rd_i,
  output reg  [31:0]         reg_rdata_o,
  output wire                crystal_ref_load_caps_en_o,
  output wire [NCH-1:0]      output_enable_o,
  output wire [NCH-1:0]      lock_lost_flag_o,
  output wire [4*NCH-1:0]    channel_mode_o,
  output wire [2*NCH-1:0]    selected_input_o,
  output wire [NCH-1:0]      phase_buildout_o,
  output wire [FO_W*NCH-1:0] freq_offset_o,
  output wire                ref_pin_signal_loss_o,
  output wire [3:0]          signal_loss_flag_o,
  output wire [3:0]          off_frequency_flag_o
);
  localparam [31:0] LOCK_CYC = `LOCK_CYC;

  reg  [31:0] ctrl, mon_cfg, los_sens, oof_cfg;
  reg  [31:0] sticky;
  reg  [7:0]  prediv_cnt;
  reg         ref_tick;
  reg  [NCH-1:0] up_s1, up_s2, up_s3, dn_s1, dn_s2, dn_s3;

  wire [3:0]  in_edge;
  wire        ref_edge;
  wire [3:0]  signal_loss_flag;
  wire [3:0]  off_frequency_flag;
  wire        ref_los;
  wire [NCH-1:0]      lock_lost_flag;
  wire [32*NCH-1:0]   cfg_flat;
  wire [FSW_W*NCH-1:0] fsw_flat;
  wire [31:0] status;
  wire [3:0]  valid = ~signal_loss_flag & ~off_frequency_flag;
  wire        wr_ctrl   = reg_wr_i && reg_addr_i == `REG_CTRL;
  wire        wr_sticky = reg_wr_i && reg_addr_i == `REG_STICKY;
  wire [3:0]  grp = reg_addr_i[7:4];
  wire [1:0]  sel_ch = reg_addr_i[3:2];

  // Highest priority is the lowest value; ties go to the lower input
  function [2:0] pick_best;
    input [3:0] v;
    input [7:0] p;
    integer     k;
    reg   [1:0] bp;
    begin
      pick_best = 3'b000;
      bp = 2'b11;
      for (k = 0; k < 4; k = k + 1) begin
        if (v[k] && (!pick_best[2] || p[2*k +: 2] < bp)) begin
          pick_best = {1'b1, k[1:0]};
          bp = p[2*k +: 2];
        end
      end
    end
  endfunction

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctrl     <= `CTRL_RESET;
      mon_cfg  <= `MON_CFG_RESET;
      los_sens <= `LOS_SENS_RESET;
      oof_cfg  <= `OOF_CFG_RESET;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `REG_CTRL:     ctrl     <= reg_wdata_i;
        `REG_MON_CFG:  mon_cfg  <= reg_wdata_i;
        `REG_LOS_SENS: los_sens <= reg_wdata_i;
        `REG_OOF_CFG:  oof_cfg  <= reg_wdata_i;
        default:       ctrl     <= ctrl;
      endcase
    end
  end

  assign crystal_ref_load_caps_en_o = ~ctrl[`CTRL_EXT_REF];

  // Predivider restarts on rewrite so a new ratio takes effect cleanly
  always @(posedge clock_i) begin
    if (!rst_n_i || wr_ctrl) begin
      prediv_cnt <= 8'h00;
      ref_tick   <= 1'b0;
    end else begin
      ref_tick <= 1'b0;
      if (ref_edge) begin
        if (prediv_cnt >= ctrl[`CTRL_PREDIV_LSB +: 8]) begin
          prediv_cnt <= 8'h00;
          ref_tick   <= 1'b1;
        end else begin
          prediv_cnt <= prediv_cnt + 8'h01;
        end
      end
    end
  end

  reg zero_tick;
  always @* begin
    case (ctrl[`CTRL_OOFREF_LSB +: 3])
      3'h1:    zero_tick = in_edge[0];
      3'h2:    zero_tick = in_edge[1];
      3'h3:    zero_tick = in_edge[2];
      3'h4:    zero_tick = in_edge[3];
      default: zero_tick = ref_tick;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_in
      clock_monitor #(
        .PREC_WIN (PREC_WIN),
        .FAST_WIN (FAST_WIN)
      ) u_mon (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .clk_pin_i  (clock_input_i[g]),
        .ref_tick_i (zero_tick),
        .los_dis_i  (mon_cfg[g]),
        .los_sens_i (los_sens[8*g +: 8]),
        .prec_dis_i (mon_cfg[`MON_PREC_DIS]),
        .fast_dis_i (mon_cfg[`MON_FAST_DIS]),
        .oof_dis_i  (1'b0),
        .oof_thr_i  (oof_cfg[7:0]),
        .oof_hys_i  (oof_cfg[`OOF_HYS_LSB +: 8]),
        .edge_o     (in_edge[g]),
        .los_o      (signal_loss_flag[g]),
        .oof_o      (off_frequency_flag[g])
      );
    end
  endgenerate

  clock_monitor #(
    .PREC_WIN (PREC_WIN),
    .FAST_WIN (FAST_WIN)
  ) u_ref_mon (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n_i),
    .clk_pin_i  (ref_pin_i),
    .ref_tick_i (1'b0),
    .los_dis_i  (mon_cfg[`MON_REF_LOS_DIS]),
    .los_sens_i (oof_cfg[`REFLOS_SENS_LSB +: 8]),
    .prec_dis_i (1'b1),
    .fast_dis_i (1'b1),
    .oof_dis_i  (1'b1),
    .oof_thr_i  (8'h00),
    .oof_hys_i  (8'h00),
    .edge_o     (ref_edge),
    .los_o      (ref_los),
    .oof_o      ()
  );

  assign signal_loss_flag_o    = signal_loss_flag;
  assign off_frequency_flag_o  = off_frequency_flag;
  assign ref_pin_signal_loss_o = ref_los;
  assign output_enable_o = {NCH{~(ref_los & ~ctrl[`CTRL_KEEP_OUT])}};

  assign status = {{(16-NCH){1'b0}}, lock_lost_flag, 4'h0, off_frequency_flag, 3'h0, ref_los, signal_loss_flag};

  // Set wins over a write-one clear in the same cycle
  always @(posedge clock_i) begin
    if (!rst_n_i)
      sticky <= 32'h0000_0000;
    else
      sticky <= (sticky & ~(wr_sticky ? reg_wdata_i : 32'h0000_0000)) | status;
  end

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      up_s1 <= {NCH{1'b0}};
      up_s2 <= {NCH{1'b0}};
      up_s3 <= {NCH{1'b0}};
      dn_s1 <= {NCH{1'b0}};
      dn_s2 <= {NCH{1'b0}};
      dn_s3 <= {NCH{1'b0}};
    end else begin
      up_s1 <= freq_step_up_i;
      up_s2 <= up_s1;
      up_s3 <= up_s2;
      dn_s1 <= freq_step_down_i;
      dn_s2 <= dn_s1;
      dn_s3 <= dn_s2;
    end
  end

  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      reg  [31:0]      cfg;
      reg  [FSW_W-1:0] freq_step_word;
      reg  [3:0]       mode;
      reg  [1:0]       sel;
      reg  [31:0]      lock_cnt;
      reg              lost;
      reg              buildout;
      reg  [FO_W-1:0]  offset;
      wire             wr_cfg = reg_wr_i && grp == `GRP_CH_CFG && sel_ch == g;
      wire             wr_fsw = reg_wr_i && grp == `GRP_CH_STEP && sel_ch == g;
      wire [2:0]       best   = pick_best(valid, cfg[`CH_PRIO_LSB +: 8]);
      wire [1:0]       msel   = cfg[`CH_MSEL_LSB +: 2];
      wire             is_auto = cfg[`CH_AUTO];
      wire             keep   = valid[sel] && !cfg[`CH_REVERT] && !mode[0];
      wire             have   = is_auto ? (keep || best[2]) : ~signal_loss_flag[msel];
      wire [1:0]       want   = is_auto ? (keep ? sel : best[1:0]) : msel;
      wire             step_up = (up_s2[g] & ~up_s3[g]) | (wr_cfg & reg_wdata_i[`CH_CMD_UP]);
      wire             step_dn = (dn_s2[g] & ~dn_s3[g]) | (wr_cfg & reg_wdata_i[`CH_CMD_DOWN]);
      wire             can_step = mode == `MODE_FREERUN || mode == `MODE_LOCKED;
      reg  [3:0]       next_mode;

      always @* begin
        next_mode = mode;
        case (mode)
          `MODE_FREERUN:  if (have) next_mode = `MODE_ACQUIRE;
          `MODE_ACQUIRE:  if (!have) next_mode = `MODE_HOLDOVER;
                          else if (want == sel && lock_cnt >= LOCK_CYC - 1) next_mode = `MODE_LOCKED;
          `MODE_LOCKED:   if (!have) next_mode = `MODE_HOLDOVER;
                          else if (want != sel) next_mode = `MODE_ACQUIRE;
          `MODE_HOLDOVER: if (have) next_mode = `MODE_ACQUIRE;
          default:        next_mode = `MODE_FREERUN;
        endcase
      end

      always @(posedge clock_i) begin
        if (!rst_n_i) begin
          cfg      <= `CH_CFG_RESET;
          freq_step_word      <= {FSW_W{1'b0}};
          mode     <= `MODE_FREERUN;
          sel      <= 2'b00;
          lock_cnt <= 32'h0000_0000;
          lost     <= 1'b1;
          buildout <= 1'b0;
          offset   <= {FO_W{1'b0}};
        end else begin
          if (wr_cfg)
            cfg <= {2'b00, reg_wdata_i[29:0]};
          if (wr_fsw)
            freq_step_word <= reg_wdata_i[FSW_W-1:0];
          mode <= next_mode;
          if (have)
            sel <= want;
          // Lock time restarts whenever the selection moves
          if (next_mode != `MODE_ACQUIRE || want != sel)
            lock_cnt <= 32'h0000_0000;
          else
            lock_cnt <= lock_cnt + 32'h0000_0001;
          lost <= next_mode != `MODE_LOCKED;
          // Phase build-out for any switch made while locked, even when the old input has failed
          buildout <= cfg[`CH_HITLESS] && mode == `MODE_LOCKED && have && want != sel;
          if (can_step && step_up && !step_dn)
            offset <= offset + {{(FO_W-FSW_W){1'b0}}, freq_step_word};
          else if (can_step && step_dn && !step_up)
            offset <= offset - {{(FO_W-FSW_W){1'b0}}, freq_step_word};
        end
      end

      assign cfg_flat[32*g +: 32]          = cfg;
      assign fsw_flat[FSW_W*g +: FSW_W]    = freq_step_word;
      assign lock_lost_flag[g]                        = lost;
      assign lock_lost_flag_o[g]           = lost;
      assign channel_mode_o[4*g +: 4]      = mode;
      assign selected_input_o[2*g +: 2]    = sel;
      assign phase_buildout_o[g]           = buildout;
      assign freq_offset_o[FO_W*g +: FO_W] = offset;
    end
  endgenerate

  // Unmapped addresses read as zero
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `REG_CTRL:     reg_rdata_o <= ctrl;
        `REG_MON_CFG:  reg_rdata_o <= mon_cfg;
        `REG_LOS_SENS: reg_rdata_o <= los_sens;
        `REG_OOF_CFG:  reg_rdata_o <= oof_cfg;
        `REG_STATUS:   reg_rdata_o <= status;
        `REG_STICKY:   reg_rdata_o <= sticky;
        default: begin
          if (sel_ch >= NCH)
            reg_rdata_o <= 32'h0000_0000;
          else if (grp == `GRP_CH_CFG)
            reg_rdata_o <= cfg_flat[32*sel_ch +: 32];
          else if (grp == `GRP_CH_STEP)
            reg_rdata_o <= {{(32-FSW_W){1'b0}}, fsw_flat[FSW_W*sel_ch +: FSW_W]};
          else if (grp == `GRP_CH_STAT)
            reg_rdata_o <= {24'h000000, lock_lost_flag[sel_ch], 1'b0, selected_input_o[2*sel_ch +: 2],
                            channel_mode_o[4*sel_ch +: 4]};
          else if (grp == `GRP_CH_OFFSET)
            reg_rdata_o <= freq_offset_o[FO_W*sel_ch +: 32];
          else
            reg_rdata_o <= 32'h0000_0000;
        end
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end
endmodule

//--- sim/clock_source_model.sv
// Purpose: Four input clocks and the reference pin clock
// Assumes: All sources share one nominal rate, an eighth of clock_i
// Notes:   A stopped source holds its level, as a dead oscillator would
`timescale 1ns/100ps
module clock_source_model (
  input  wire       clock_i,
  input  wire [3:0] stop_i,
  input  wire       ref_stop_i,
  output reg  [3:0] clk_o,
  output reg        ref_o
);
  reg [1:0] div = 2'h0;
  initial clk_o = 4'h0;
  initial ref_o = 1'b0;
  // Clocks are gapped only by stop_i and ref_stop_i, so gap limits hold trivially while they run
  always @(posedge clock_i) begin
    div <= div + 2'h1;
    if (div == 2'h3) begin
      clk_o <= clk_o ^ ~stop_i;
      ref_o <= ref_o ^ ~ref_stop_i;
    end
  end
endmodule

//--- sim/pll_sel_props.sv
// Purpose: Port properties of input select and fault monitor
// Assumes: Shadow config copies follow register writes
// Notes:   Per-channel checks watch channels 0 and 1, except AST_LOL, AST_OUT_OFF and AST_OUT_KEEP which cover every channel
`timescale 1ns/100ps
`include "pll_sel_consts.vh"
module pll_sel_props #(
  parameter NCH  = 4,
  parameter FO_W = 32
) (
  input wire                clock_i,
  input wire                rst_n_i,
  input wire [7:0]          reg_addr_i,
  input wire [31:0]         reg_wdata_i,
  input wire                reg_wr_i,
  input wire                crystal_ref_load_caps_en_o,
  input wire [NCH-1:0]      output_enable_o,
  input wire [NCH-1:0]      lock_lost_flag_o,
  input wire [4*NCH-1:0]    channel_mode_o,
  input wire [2*NCH-1:0]    selected_input_o,
  input wire [NCH-1:0]      phase_buildout_o,
  input wire [FO_W*NCH-1:0] freq_offset_o,
  input wire                ref_pin_signal_loss_o,
  input wire [3:0]          signal_loss_flag_o,
  input wire [3:0]          off_frequency_flag_o
);
  reg  [1:0]     ctrl;
  reg  [9:0]     mon;
  reg            hit0;
  reg  [2:0]     cfg1;
  reg  [1:0]     age;
  reg  [NCH-1:0] lol_exp;
  wire [3:0]     mode0 = channel_mode_o[3:0];
  integer        c;
  always @* begin
    for (c = 0; c < NCH; c = c + 1) lol_exp[c] = ~channel_mode_o[4*c+2];
  end
  // Age gives the design a few cycles to settle after a config write
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctrl <= 2'h0;
      mon  <= 10'h0;
      hit0 <= 1'b0;
      cfg1 <= 3'h1;
      age  <= 2'h0;
    end else if (reg_wr_i) begin
      age <= 2'h0;
      if (reg_addr_i == 8'h00) ctrl <= reg_wdata_i[1:0];
      if (reg_addr_i == 8'h04) mon <= reg_wdata_i[9:0];
      if (reg_addr_i == 8'h20) hit0 <= reg_wdata_i[4];
      if (reg_addr_i == 8'h24) cfg1 <= reg_wdata_i[2:0];
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence ref_down; ref_pin_signal_loss_o && !ctrl[1]; endsequence
  sequence no_step; mode0 != `MODE_FREERUN && mode0 != `MODE_LOCKED; endsequence
  AST_CAPS: assert property (reg_wr_i && reg_addr_i == 8'h00 |=>
    crystal_ref_load_caps_en_o == !$past(reg_wdata_i[0])) else $error("load capacitor enable wrong");
  AST_OUT_OFF: assert property (ref_down ##1 ref_down |-> output_enable_o == {NCH{1'b0}})
    else $error("outputs run during reference loss");
  AST_OUT_KEEP: assert property (ctrl[1] ##1 ctrl[1] |-> output_enable_o == {NCH{1'b1}})
    else $error("outputs stopped although kept on");
  AST_LOL: assert property (lock_lost_flag_o == lol_exp)
    else $error("lock lost flag disagrees with mode");
  AST_HOLD: assert property (mode0 == `MODE_LOCKED && (&signal_loss_flag_o) |->
    ##[1:4] mode0 == `MODE_HOLDOVER) else $error("no holdover without inputs");
  AST_STEP_IDLE: assert property (no_step ##1 no_step |=> $stable(freq_offset_o[FO_W-1:0]))
    else $error("offset moved outside free-run and locked");
  AST_MAN_SEL: assert property (!cfg1[0] && age == 2'h3 |-> selected_input_o[3:2] == cfg1[2:1])
    else $error("manual selection not followed");
  AST_LOS_DIS: assert property (age == 2'h3 |-> (signal_loss_flag_o & mon[3:0]) == 4'h0)
    else $error("disabled signal loss monitor flags");
  AST_REF_DIS: assert property (age == 2'h3 && mon[4] |-> !ref_pin_signal_loss_o)
    else $error("disabled reference monitor flags");
  AST_OOF_DIS: assert property (age == 2'h3 && (&mon[9:8]) |-> off_frequency_flag_o == 4'h0)
    else $error("disabled frequency monitors flag");
  AST_HITLESS: assert property (phase_buildout_o[0] |-> $past(hit0))
    else $error("phase absorbed with hitless off");
  AST_HITLESS_SW: assert property ($changed(selected_input_o[1:0]) && $past(mode0) == `MODE_LOCKED &&
    $past(hit0) |-> phase_buildout_o[0]) else $error("no phase absorption on hitless switch");
  AST_SWITCH_LOL: assert property ($changed(selected_input_o[1:0]) && $past(mode0) == `MODE_LOCKED |->
    ##[0:2] lock_lost_flag_o[0]) else $error("no lock lost flag on switch");
endmodule
bind pll_input_select_fault_monitor pll_sel_props #(.NCH(NCH), .FO_W(FO_W)) props (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .crystal_ref_load_caps_en_o(crystal_ref_load_caps_en_o), .output_enable_o(output_enable_o),
  .lock_lost_flag_o(lock_lost_flag_o), .channel_mode_o(channel_mode_o), .selected_input_o(selected_input_o),
  .phase_buildout_o(phase_buildout_o), .freq_offset_o(freq_offset_o),
  .ref_pin_signal_loss_o(ref_pin_signal_loss_o), .signal_loss_flag_o(signal_loss_flag_o),
  .off_frequency_flag_o(off_frequency_flag_o));

//--- sim/pll_input_select_fault_monitor_tb.sv
// Purpose: Self-checking bench for input select and fault monitor
// Assumes: Inputs and reference share one nominal rate
// Notes:   Short monitor windows keep the run brief
`timescale 1ns/100ps
`include "pll_sel_consts.vh"
module pll_input_select_fault_monitor_tb;
  reg          clock_i;
  reg          rst_n_i;
  reg          reg_wr_i;
  reg          reg_rd_i;
  reg          ref_stop;
  reg          rd_q = 1'b0;
  reg  [3:0]   stop;
  reg  [3:0]   step_up;
  reg  [3:0]   step_down;
  reg  [7:0]   reg_addr_i;
  reg  [31:0]  reg_wdata_i;
  reg  [23:0]  w;
  reg  [1:0]   r;
  reg  [7:0]   p;
  reg  [31:0]  exp_q[$];
  reg  [31:0]  mask_q[$];
  wire [3:0]   clk_in;
  wire         ref_pin;
  wire [31:0]  rdata;
  wire         caps;
  wire         ref_los;
  wire [3:0]   oe;
  wire [3:0]   lock_lost_flag;
  wire [3:0]   signal_loss_flag;
  wire [3:0]   off_frequency_flag;
  wire [15:0]  mode;
  wire [7:0]   sel;
  wire [127:0] offs;
  integer      error_cnt;
  integer      checked;
  integer      cycles;
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  clock_source_model src (.clock_i(clock_i), .stop_i(stop), .ref_stop_i(ref_stop), .clk_o(clk_in), .ref_o(ref_pin));
  pll_input_select_fault_monitor #(.PREC_WIN(64), .FAST_WIN(16)) dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .clock_input_i(clk_in), .ref_pin_i(ref_pin),
    .freq_step_up_i(step_up), .freq_step_down_i(step_down), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
    .crystal_ref_load_caps_en_o(caps), .output_enable_o(oe), .lock_lost_flag_o(lock_lost_flag), .channel_mode_o(mode),
    .selected_input_o(sel), .phase_buildout_o(), .freq_offset_o(offs), .ref_pin_signal_loss_o(ref_los),
    .signal_loss_flag_o(signal_loss_flag), .off_frequency_flag_o(off_frequency_flag));
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("mismatches %0d comparisons %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clock_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clock_i);
      reg_wr_i    <= 1'b0;
    end
  endtask
  // Expected value goes on the queue before the strobe
  task rd(input [7:0] a, input [31:0] e, input [31:0] m);
    begin
      exp_q.push_back(e & m);
      mask_q.push_back(m);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clock_i);
      reg_rd_i   <= 1'b0;
    end
  endtask
  task pin(input [3:0] u, input [3:0] d);
    begin
      @(posedge clock_i);
      step_up   <= u;
      step_down <= d;
      repeat (5) @(posedge clock_i);
      step_up   <= 4'h0;
      step_down <= 4'h0;
      repeat (6) @(posedge clock_i);
    end
  endtask
  task wait_eq(input [5:0] v, input [5:0] m);
    integer k;
    begin
      k = 0;
      while (({mode[3:0], sel[1:0]} & m) !== v && k < 4000) begin
        @(negedge clock_i);
        k = k + 1;
      end
      chk({mode[3:0], sel[1:0]} & m, v);
    end
  endtask
  always @(posedge clock_i) begin
    if (rd_q) chk(rdata & mask_q.pop_front(), exp_q.pop_front());
    rd_q   <= reg_rd_i;
    cycles = cycles + 1;
    if (cycles == 60000) begin
      error_cnt = error_cnt + 1;
      summarize;
    end
  end
  initial begin
    rst_n_i = 1'b0; reg_wr_i = 1'b0; reg_rd_i = 1'b0; reg_addr_i = 8'h0; reg_wdata_i = 32'h0;
    stop = 4'h0; ref_stop = 1'b0; step_up = 4'h0; step_down = 4'h0;
    error_cnt = 0; checked = 0; cycles = 0;
    w = $urandom(80);
    w = $urandom;
    r = $urandom;
    p = $urandom;
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(`REG_CTRL, `CTRL_RESET, 32'hffff_ffff);
    rd(`REG_LOS_SENS, `LOS_SENS_RESET, 32'hffff_ffff);
    rd(`REG_OOF_CFG, `OOF_CFG_RESET, 32'hffff_ffff);
    rd(8'h20, `CH_CFG_RESET, 32'hffff_ffff);
    rd(8'hfc, 32'h0, 32'hffff_ffff);
    wr(`REG_LOS_SENS, 32'h0404_0404);
    wr(`REG_OOF_CFG, 32'h0010_0204);
    wr(8'h20, 32'h0000_4b19);
    wr(8'h24, {29'h0, r, 1'b0});
    wr(8'h30, {8'h0, w});
    wait_eq({`MODE_LOCKED, 2'h2}, 6'h3f);
    repeat (20) @(negedge clock_i);
    chk({mode[7:4], sel[3:2]}, {`MODE_LOCKED, r});
    wr(8'h20, 32'h4000_4b19);
    wr(8'h20, 32'h8000_4b19);
    wr(8'h20, 32'h8000_4b19);
    rd(8'h50, 32'h0 - {8'h0, w}, 32'hffff_ffff);
    pin(4'h1, 4'h0);
    chk(offs[31:0], 32'h0);
    pin(4'h0, 4'h1);
    chk(offs[31:0], 32'h0 - {8'h0, w});
    stop <= 4'h4;
    wait_eq({`MODE_ACQUIRE, 2'h3}, 6'h3f);
    chk(lock_lost_flag[0], 1'b1);
    wr(8'h20, 32'h4000_4b19);
    repeat (3) @(negedge clock_i);
    chk(offs[31:0], 32'h0 - {8'h0, w});
    wait_eq({`MODE_LOCKED, 2'h3}, 6'h3f);
    chk(mode[7:4], (r == 2'h2) ? `MODE_HOLDOVER : `MODE_LOCKED);
    stop <= 4'h0;
    wait_eq({`MODE_LOCKED, 2'h2}, 6'h3f);
    wr(8'h20, 32'h0000_4b11);
    stop <= 4'h4;
    wait_eq({`MODE_LOCKED, 2'h3}, 6'h3f);
    stop <= 4'h0;
    repeat (1500) @(negedge clock_i);
    chk(sel[1:0], 2'h3);
    // Two missing periods on the locked input must not raise its loss or off-frequency flag or channel 0 lock lost
    wr(`REG_STICKY, 32'hffff_ffff);
    stop <= 4'h8;
    repeat (16) @(posedge clock_i);
    stop <= 4'h0;
    repeat (600) @(posedge clock_i);
    rd(`REG_STICKY, 32'h0, 32'h0001_0808);
    stop <= 4'hf;
    wait_eq({`MODE_HOLDOVER, 2'h0}, 6'h3c);
    rd(`REG_STICKY, 32'h0000_000f, 32'h0000_000f);
    wr(`REG_MON_CFG, 32'h0000_031f);
    repeat (4) @(negedge clock_i);
    chk({ref_los, signal_loss_flag, off_frequency_flag}, 9'h0);
    stop <= 4'h0;
    repeat (50) @(posedge clock_i);
    wr(`REG_MON_CFG, 32'h0);
    repeat (20) @(negedge clock_i);
    chk(signal_loss_flag, 4'h0);
    wr(`REG_STICKY, 32'hffff_ffff);
    rd(`REG_STICKY, 32'h0, 32'h0000_000f);
    ref_stop <= 1'b1;
    repeat (300) @(negedge clock_i);
    chk({ref_los, oe}, 5'h10);
    wr(`REG_CTRL, {16'h0, p, 8'h03});
    repeat (3) @(negedge clock_i);
    chk({caps, oe}, 5'h0f);
    rd(`REG_CTRL, {16'h0, p, 8'h03}, 32'h0000_ff03);
    wr(`REG_MON_CFG, 32'h0000_0010);
    repeat (4) @(negedge clock_i);
    chk(ref_los, 1'b0);
    repeat (4) @(posedge clock_i);
    summarize;
  end
endmodule
